// [rtl/rxs_pkg.sv]
package rxs_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned ADDR_W   = 5;
	localparam int unsigned NPORTS   = 4;
	localparam int unsigned PIDX_W   = 2;
	localparam int unsigned LEVEL_W  = 8;
	localparam int unsigned SYNC_LEN = 2;

	// ==========================================================
	// Modes
	typedef enum logic [1:0] {
		RXS_UTOPIA_L2,
		RXS_UTOPIA_L3,
		RXS_PACKET_L2,
		RXS_SPI3
	} rxs_bus_mode_e;

	typedef enum logic [1:0] {
		RXS_W8,
		RXS_W16,
		RXS_W32
	} rxs_width_e;

	// ==========================================================
	// Carriers
	typedef struct packed {
		rxs_bus_mode_e            bus_mode;
		rxs_width_e               width;
		logic                     direct_status;
		logic                     parity_en;
		logic                     parity_odd;
		logic [LEVEL_W-1:0]       almost_empty;
	} rxs_cfg_s;

	typedef struct packed {
		logic [LEVEL_W-1:0] level;
		logic               eop_ready;
	} rxs_port_s;

	// ==========================================================
	// Values after reset, drive enables and lane masks
	localparam rxs_cfg_s CFG_RST = '{
		bus_mode:      RXS_UTOPIA_L2,
		width:         RXS_W8,
		direct_status: 1'b0,
		parity_en:     1'b0,
		parity_odd:    1'b0,
		almost_empty:  8'h00
	};
	localparam logic [DATA_W-1:0] OE_ALL_OFF = 32'hffff_ffff;
	localparam logic [DATA_W-1:0] OE_ALL_ON  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] LANES_8    = 32'h0000_00ff;
	localparam logic [DATA_W-1:0] LANES_16   = 32'h0000_ffff;
	localparam logic [DATA_W-1:0] LANES_32   = 32'hffff_ffff;
	localparam logic [DATA_W-1:0] DATA_RST   = 32'h0000_0000;

endpackage : rxs_pkg

// [rtl/rxs_sync.sv]
`timescale 1ns/1ns
module rxs_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         CLK,
	input  wire logic         RST,
	input  wire logic [W-1:0] D,
	output logic      [W-1:0] Q
);

	// ==========================================================
	// Two-stage synchroniser, first stage read only by the second
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = D;
		q_nxt    = meta_r;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign Q = q_r;

endmodule : rxs_sync

// [rtl/rxs_rx_sys_if.sv]
// Behaviour
// - Receive data leaves on a 32-bit bus, changing only at link clock rising edges.
// - In 32-bit width bit 31 is most significant, bit 0 least.
// - Level 2 drives data only while a port is selected and enable is low.
// - Level 3 and SPI-3 style drive all 32 data lines continuously.
// - 16-bit width uses bits 15:0; upper lines tri-stated in level 2.
// - Reset width is 8 bits; bits 31:8 tri-stated in level 2.
// - Global reset tri-states the data bus and the multi-function pin.
// - Parity pin carries data parity when enabled, otherwise held low.
// - Parity updates at link edges and follows the data bus drive conditions.
// - Active-low read enable low requests a transfer; high suppresses it.
// - Direct status mode: multi-function pin is port 0 available flag.
// - Cell modes: flag rises above almost-empty count, falls without a full cell.
// - Packet level 2: flag high above almost-empty or with end of packet.
// - Polled status mode, the reset default, reports the addressed port's availability.
// - SPI-3 style: pin marks start of transfer while in-band address is on data.
`timescale 1ns/1ns
module rxs_rx_sys_if (
	input  wire logic                                          CLK,
	input  wire logic                                          RST,
	input  wire logic                                          RX_SYSTEM_CLOCK,
	input  wire logic                                          RX_READ_EN_N,
	input  wire logic [rxs_pkg::ADDR_W-1:0]                     RX_PORT_ADDR,
	input  wire logic                                          DP_RESET,
	input  wire rxs_pkg::rxs_cfg_s                              CFG,
	input  wire rxs_pkg::rxs_port_s [rxs_pkg::NPORTS-1:0]       PORT_STAT,
	input  wire logic [rxs_pkg::DATA_W-1:0]                     WORD_IN,
	output logic      [rxs_pkg::PIDX_W-1:0]                     PORT_SEL,
	output logic                                               WORD_TAKE,
	output logic      [rxs_pkg::DATA_W-1:0]                     RX_DATA,
	output logic      [rxs_pkg::DATA_W-1:0]                     RX_DATA_OE_N,
	output logic                                               RX_SYS_PARITY,
	output logic                                               RX_SYS_PARITY_OE_N,
	output logic                                               RX_MF_OUT,
	output logic                                               RX_MF_OE_N
);

	// ==========================================================
	// Link side sampling
	logic                         lclk_s;
	logic                         ren_n_s;
	logic [rxs_pkg::ADDR_W-1:0]   addr_s;
	logic                         dpr_s;
	logic                         lclk_d_r;
	logic                         lclk_d_nxt;
	logic                         edge_w;

	rxs_sync #(.W(1)) u_sync_clk (
		.CLK (CLK),
		.RST (RST),
		.D   (RX_SYSTEM_CLOCK),
		.Q   (lclk_s)
	);

	rxs_sync #(.W(rxs_pkg::ADDR_W + 2)) u_sync_ctl (
		.CLK (CLK),
		.RST (RST),
		.D   ({RX_READ_EN_N, DP_RESET, RX_PORT_ADDR}),
		.Q   ({ren_n_s, dpr_s, addr_s})
	);

	always_comb begin
		lclk_d_nxt = lclk_s;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lclk_d_r <= 1'b0;
		end else begin
			lclk_d_r <= lclk_d_nxt;
		end
	end

	assign edge_w = lclk_s & ~lclk_d_r;

	// ==========================================================
	// Configuration decode
	logic level3_w;
	logic spi3_w;
	logic packet_w;
	logic [rxs_pkg::DATA_W-1:0] lanes_w;

	always_comb begin
		spi3_w   = (CFG.bus_mode == rxs_pkg::RXS_SPI3);
		level3_w = (CFG.bus_mode == rxs_pkg::RXS_UTOPIA_L3) | spi3_w;
		packet_w = (CFG.bus_mode == rxs_pkg::RXS_PACKET_L2);
		case (CFG.width)
			rxs_pkg::RXS_W16: lanes_w = rxs_pkg::LANES_16;
			rxs_pkg::RXS_W32: lanes_w = rxs_pkg::LANES_32;
			default:          lanes_w = rxs_pkg::LANES_8;
		endcase
	end

	// ==========================================================
	// Per-port available flags
	logic [rxs_pkg::NPORTS-1:0] avail_r;
	logic [rxs_pkg::NPORTS-1:0] avail_nxt;

	genvar gp;
	generate
		for (gp = 0; gp < rxs_pkg::NPORTS; gp++) begin : g_avail
			logic above_w;
			logic empty_w;
			assign above_w = PORT_STAT[gp].level > CFG.almost_empty;
			assign empty_w = PORT_STAT[gp].level == '0;
			assign avail_nxt[gp] = !edge_w ? avail_r[gp] :
				packet_w ? (above_w | PORT_STAT[gp].eop_ready) :
				above_w ? 1'b1 : (empty_w ? 1'b0 : avail_r[gp]);
		end
	endgenerate

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			avail_r <= '0;
		end else begin
			avail_r <= avail_nxt;
		end
	end

	// ==========================================================
	// Transfer path
	logic [rxs_pkg::PIDX_W-1:0]   sel_r;
	logic [rxs_pkg::PIDX_W-1:0]   sel_nxt;
	logic                         sel_ok_r;
	logic                         sel_ok_nxt;
	logic [rxs_pkg::DATA_W-1:0]   data_r;
	logic [rxs_pkg::DATA_W-1:0]   data_nxt;
	logic [rxs_pkg::DATA_W-1:0]   oe_n_r;
	logic [rxs_pkg::DATA_W-1:0]   oe_n_nxt;
	logic                         par_r;
	logic                         par_nxt;
	logic                         par_oe_n_r;
	logic                         par_oe_n_nxt;
	logic                         mf_r;
	logic                         mf_nxt;
	logic                         mf_oe_n_r;
	logic                         mf_oe_n_nxt;
	logic                         take_r;
	logic                         take_nxt;
	logic                         addr_ok_w;
	logic [rxs_pkg::PIDX_W-1:0]   pick_w;
	logic                         any_w;

	assign addr_ok_w = addr_s < rxs_pkg::ADDR_W'(rxs_pkg::NPORTS);

	always_comb begin
		pick_w = '0;
		any_w  = 1'b0;
		for (int i = rxs_pkg::NPORTS - 1; i >= 0; i--) begin
			if (avail_r[i]) begin
				pick_w = rxs_pkg::PIDX_W'(i);
				any_w  = 1'b1;
			end
		end
	end

	// Outside SPI-3 style, enable high only moves the selection; enable low moves a word from it
	always_comb begin
		sel_nxt      = sel_r;
		sel_ok_nxt   = sel_ok_r;
		data_nxt     = data_r;
		oe_n_nxt     = oe_n_r;
		par_nxt      = par_r;
		par_oe_n_nxt = par_oe_n_r;
		mf_nxt       = mf_r;
		mf_oe_n_nxt  = mf_oe_n_r;
		take_nxt     = 1'b0;
		if (edge_w) begin
			mf_nxt = 1'b0;
			if (spi3_w) begin
				sel_ok_nxt = 1'b1;
				if (!ren_n_s) begin
					// A newly selected port costs one transfer slot for its in-band address
					if (any_w && (pick_w != sel_r || !sel_ok_r)) begin
						sel_nxt  = pick_w;
						data_nxt = rxs_pkg::DATA_W'(pick_w);
						mf_nxt   = 1'b1;
					end else begin
						data_nxt = WORD_IN & lanes_w;
						take_nxt = 1'b1;
					end
				end
				mf_oe_n_nxt = 1'b0;
			end else begin
				if (ren_n_s) begin
					sel_nxt    = addr_s[rxs_pkg::PIDX_W-1:0];
					sel_ok_nxt = addr_ok_w;
				end else if (sel_ok_r && !dpr_s) begin
					data_nxt = WORD_IN & lanes_w;
					take_nxt = 1'b1;
				end
				// Flags use this edge's fill, so the pin is not a link cycle late
				if (CFG.direct_status) begin
					mf_nxt      = avail_nxt[0];
					mf_oe_n_nxt = 1'b0;
				end else begin
					mf_nxt      = addr_ok_w & avail_nxt[addr_s[rxs_pkg::PIDX_W-1:0]];
					mf_oe_n_nxt = !(level3_w | (addr_ok_w & !dpr_s));
				end
			end
			// Level 3 keeps driving through data-path reset
			if (level3_w) begin
				oe_n_nxt = rxs_pkg::OE_ALL_ON;
			end else if (!ren_n_s && sel_ok_r && !dpr_s) begin
				oe_n_nxt = ~lanes_w;
			end else begin
				oe_n_nxt = rxs_pkg::OE_ALL_OFF;
			end
			par_nxt      = CFG.parity_en & ((^(data_nxt & lanes_w)) ^ CFG.parity_odd);
			par_oe_n_nxt = level3_w ? 1'b0 : (&oe_n_nxt);
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sel_r      <= '0;
			sel_ok_r   <= 1'b0;
			data_r     <= rxs_pkg::DATA_RST;
			oe_n_r     <= rxs_pkg::OE_ALL_OFF;
			par_r      <= 1'b0;
			par_oe_n_r <= 1'b1;
			mf_r       <= 1'b0;
			mf_oe_n_r  <= 1'b1;
			take_r     <= 1'b0;
		end else begin
			sel_r      <= sel_nxt;
			sel_ok_r   <= sel_ok_nxt;
			data_r     <= data_nxt;
			oe_n_r     <= oe_n_nxt;
			par_r      <= par_nxt;
			par_oe_n_r <= par_oe_n_nxt;
			mf_r       <= mf_nxt;
			mf_oe_n_r  <= mf_oe_n_nxt;
			take_r     <= take_nxt;
		end
	end

	assign PORT_SEL           = sel_r;
	assign WORD_TAKE          = take_r;
	assign RX_DATA            = data_r;
	assign RX_DATA_OE_N       = oe_n_r;
	assign RX_SYS_PARITY      = par_r;
	assign RX_SYS_PARITY_OE_N = par_oe_n_r;
	assign RX_MF_OUT          = mf_r;
	assign RX_MF_OE_N         = mf_oe_n_r;

	// ==========================================================
	// Checks
	// Antecedents use the detect cycle, consequents the cycle the registers load; take_enable_a and sx_address_a check outputs in their load cycle
	data_stable_a: assert property (@(posedge CLK) disable iff (RST)
		!edge_w |=> $stable(RX_DATA))
		else $error("data changed without a link edge");

	l3_drive_a: assert property (@(posedge CLK) disable iff (RST)
		edge_w && level3_w |=> RX_DATA_OE_N == rxs_pkg::OE_ALL_ON)
		else $error("level 3 data bus not driven");

	l2_idle_tri_a: assert property (@(posedge CLK) disable iff (RST)
		edge_w && !level3_w && ren_n_s |=> RX_DATA_OE_N == rxs_pkg::OE_ALL_OFF)
		else $error("level 2 bus driven with enable high");

	narrow_upper_a: assert property (@(posedge CLK) disable iff (RST)
		edge_w && !level3_w && CFG.width == rxs_pkg::RXS_W8 |=> &RX_DATA_OE_N[31:8])
		else $error("upper lanes driven in 8-bit level 2");

	parity_off_a: assert property (@(posedge CLK) disable iff (RST)
		edge_w && !CFG.parity_en |=> !RX_SYS_PARITY)
		else $error("parity not held low when disabled");

	parity_value_a: assert property (@(posedge CLK) disable iff (RST)
		edge_w && CFG.parity_en && CFG.width == rxs_pkg::RXS_W32
		|=> RX_SYS_PARITY == ((^RX_DATA) ^ $past(CFG.parity_odd)))
		else $error("parity does not match data");

	direct_empty_a: assert property (@(posedge CLK) disable iff (RST)
		edge_w && !spi3_w && !packet_w && CFG.direct_status && PORT_STAT[0].level == '0 |=> !RX_MF_OUT)
		else $error("direct flag high with no cell");

	take_enable_a: assert property (@(posedge CLK) disable iff (RST)
		WORD_TAKE |-> $past(ren_n_s) == 1'b0 && $past(edge_w))
		else $error("word taken without enable low at an edge");

	sx_address_a: assert property (@(posedge CLK) disable iff (RST)
		spi3_w && RX_MF_OUT |-> RX_DATA == rxs_pkg::DATA_W'(PORT_SEL) && !WORD_TAKE)
		else $error("start of transfer without address on data");

	cell_low_a: assert property (@(posedge CLK) disable iff (RST)
		edge_w && !packet_w && PORT_STAT[0].level == '0 |=> !avail_r[0])
		else $error("available flag high with no cell");

	c_l2_take_c: cover property (@(posedge CLK) disable iff (RST) WORD_TAKE && !level3_w);
	c_spi3_sx_c: cover property (@(posedge CLK) disable iff (RST) RX_MF_OUT && spi3_w);
	c_polled_c: cover property (@(posedge CLK) disable iff (RST)
		RX_MF_OUT && !CFG.direct_status && !spi3_w);
	c_direct_c: cover property (@(posedge CLK) disable iff (RST)
		RX_MF_OUT && CFG.direct_status && !spi3_w);
	c_refused_c: cover property (@(posedge CLK) disable iff (RST)
		edge_w && !ren_n_s && dpr_s && !level3_w);

endmodule : rxs_rx_sys_if

// [verif/rxs_link_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Link-layer master: free-running link clock, requests launched mid-cycle
module rxs_link_model (
	input  wire logic       REQ_EN_N,
	input  wire logic [4:0] REQ_ADDR,
	output logic            LCLK,
	output logic            READ_EN_N,
	output logic      [4:0] PORT_ADDR
);
	initial begin
		LCLK = 1'b0;
		READ_EN_N = 1'b1;
		PORT_ADDR = 5'h00;
		#37;
		forever begin
			#200 LCLK = ~LCLK;
		end
	end
	// Launched on the falling edge so they are steady at the sampling edge
	always @(negedge LCLK) begin
		READ_EN_N <= REQ_EN_N;
		PORT_ADDR <= REQ_ADDR;
	end
endmodule : rxs_link_model

// [verif/tb_rxs_rx_sys_if.sv]
`timescale 1ns/1ns
module tb_rxs_rx_sys_if;
	logic                                 clk, rst, dp_reset, req_en_n, lclk, read_en_n;
	logic                                 word_take, par, par_oe_n, mf, mf_oe_n;
	logic [4:0]                           req_addr, port_addr;
	logic [1:0]                           port_sel;
	logic [31:0]                          word_in, rx_data, data_oe_n;
	rxs_pkg::rxs_cfg_s                    cfg;
	rxs_pkg::rxs_port_s [3:0]             port_stat;
	logic [31:0]                          lanes [3];
	int                                   bad_count, checks_done, takes, cycles;

	assign word_in = 32'hc3a5_5a10 + {30'h0, port_sel};

	rxs_link_model u_link (.REQ_EN_N(req_en_n), .REQ_ADDR(req_addr), .LCLK(lclk),
		.READ_EN_N(read_en_n), .PORT_ADDR(port_addr));

	rxs_rx_sys_if u_dut (.CLK(clk), .RST(rst), .RX_SYSTEM_CLOCK(lclk), .RX_READ_EN_N(read_en_n),
		.RX_PORT_ADDR(port_addr), .DP_RESET(dp_reset), .CFG(cfg), .PORT_STAT(port_stat),
		.WORD_IN(word_in), .PORT_SEL(port_sel), .WORD_TAKE(word_take), .RX_DATA(rx_data),
		.RX_DATA_OE_N(data_oe_n), .RX_SYS_PARITY(par), .RX_SYS_PARITY_OE_N(par_oe_n),
		.RX_MF_OUT(mf), .RX_MF_OE_N(mf_oe_n));

	initial begin
		clk = 1'b0;
		forever begin
			#25 clk = ~clk;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (word_take === 1'b1) begin
			takes++;
		end
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Enable is latched for exactly one sampling edge; an idle edge with the previous address precedes it
	task xfer(input logic en_n, input logic [4:0] addr);
		req_en_n = en_n;
		req_addr = addr;
		@(negedge lclk);
		@(posedge lclk);
		@(negedge clk);
		req_en_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask : xfer

	task finish_test;
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	initial begin
		rst = 1'b1;
		dp_reset = 1'b0;
		req_en_n = 1'b1;
		req_addr = 5'h00;
		cfg = rxs_pkg::CFG_RST;
		port_stat = '0;
		lanes = '{rxs_pkg::LANES_8, rxs_pkg::LANES_16, rxs_pkg::LANES_32};
		repeat (4) @(negedge clk);
		chk("reset data oe", data_oe_n, rxs_pkg::OE_ALL_OFF);
		chk("reset mf oe", 32'(mf_oe_n), 32'h1);
		rst = 1'b0;
		xfer(1'b1, 5'h01);
		chk("idle oe", data_oe_n, rxs_pkg::OE_ALL_OFF);
		xfer(1'b0, 5'h01);
		chk("byte data", rx_data, 32'hc3a5_5a11 & rxs_pkg::LANES_8);
		chk("byte oe", data_oe_n, ~rxs_pkg::LANES_8);
		chk("parity off", 32'(par), 32'h0);
		chk("takes", 32'(takes), 32'h1);
		cfg.parity_en = 1'b1;
		xfer(1'b1, 5'h02);
		for (int i = 0; i < 3; i++) begin
			cfg.width = rxs_pkg::rxs_width_e'(i);
			xfer(1'b0, 5'h02);
			chk("data", rx_data, 32'hc3a5_5a12 & lanes[i]);
			chk("data oe", data_oe_n, ~lanes[i]);
			chk("parity", 32'(par), 32'(^(32'hc3a5_5a12 & lanes[i])));
			chk("parity oe", 32'(par_oe_n), 32'h0);
		end
		xfer(1'b1, 5'h02);
		chk("enable high oe", data_oe_n, rxs_pkg::OE_ALL_OFF);
		xfer(1'b1, 5'h1f);
		xfer(1'b0, 5'h1f);
		chk("no port oe", data_oe_n, rxs_pkg::OE_ALL_OFF);
		chk("no port mf oe", 32'(mf_oe_n), 32'h1);
		dp_reset = 1'b1;
		xfer(1'b1, 5'h02);
		xfer(1'b0, 5'h02);
		chk("dp reset oe", data_oe_n, rxs_pkg::OE_ALL_OFF);
		chk("refused takes", 32'(takes), 32'h4);
		dp_reset = 1'b0;
		cfg.bus_mode = rxs_pkg::RXS_UTOPIA_L3;
		xfer(1'b1, 5'h1f);
		chk("l3 oe", data_oe_n, rxs_pkg::OE_ALL_ON);
		chk("l3 parity oe", 32'(par_oe_n), 32'h0);
		cfg.bus_mode = rxs_pkg::RXS_UTOPIA_L2;
		cfg.direct_status = 1'b1;
		cfg.almost_empty = 8'h02;
		port_stat[0].level = 8'h03;
		xfer(1'b1, 5'h01);
		chk("direct above", 32'(mf), 32'h1);
		port_stat[0].level = 8'h01;
		xfer(1'b1, 5'h01);
		chk("direct hold", 32'(mf), 32'h1);
		port_stat[0].level = 8'h00;
		xfer(1'b1, 5'h01);
		chk("direct empty", 32'(mf), 32'h0);
		cfg.bus_mode = rxs_pkg::RXS_PACKET_L2;
		port_stat[0].eop_ready = 1'b1;
		xfer(1'b1, 5'h01);
		chk("packet eop", 32'(mf), 32'h1);
		port_stat[0].eop_ready = 1'b0;
		xfer(1'b1, 5'h01);
		chk("packet none", 32'(mf), 32'h0);
		cfg.bus_mode = rxs_pkg::RXS_UTOPIA_L2;
		cfg.direct_status = 1'b0;
		port_stat[2].level = 8'h05;
		xfer(1'b1, 5'h02);
		chk("polled ready", 32'(mf), 32'h1);
		chk("polled mf oe", 32'(mf_oe_n), 32'h0);
		xfer(1'b1, 5'h01);
		chk("polled empty", 32'(mf), 32'h0);
		cfg.bus_mode = rxs_pkg::RXS_SPI3;
		xfer(1'b0, 5'h00);
		chk("inband addr", rx_data, 32'h0000_0002);
		chk("start flag", 32'(mf), 32'h1);
		xfer(1'b0, 5'h00);
		chk("spi3 word", rx_data, 32'hc3a5_5a12);
		chk("start ends", 32'(mf), 32'h0);
		chk("spi3 takes", 32'(takes), 32'h5);
		finish_test();
	end
endmodule : tb_rxs_rx_sys_if
